// ### rtl/jfp_pkg.sv
// constants and types for the jtag flash programming data paths
package jfp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // instruction register and opcodes
    localparam int             IR_W           = 4;
    localparam logic [IR_W-1:0] IR_CAPTURE    = 4'h1;
    localparam logic [IR_W-1:0] OP_UNLOCK     = 4'h4;
    localparam logic [IR_W-1:0] OP_CMD        = 4'h5;
    localparam logic [IR_W-1:0] OP_FILL       = 4'h6;
    localparam logic [IR_W-1:0] OP_DUMP       = 4'h7;
    localparam logic [IR_W-1:0] OP_HOLD       = 4'hC;
    localparam logic [IR_W-1:0] OP_BYPASS     = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // data register sizes and values
    localparam int                CMD_W       = 15;
    localparam logic [CMD_W-1:0]  CMD_RST     = 15'h0000;
    localparam int                UNLOCK_W    = 16;
    localparam logic [UNLOCK_W-1:0] UNLOCK_SIG = 16'hA370;
    localparam int                BYTE_W      = 8;
    localparam int                BIT_CNT_W   = 3;
    localparam logic [BIT_CNT_W-1:0] BYTE_LAST = 3'h7;
    localparam int                PAGE_BYTES  = 256;
    localparam int                PAGE_BITS   = PAGE_BYTES * BYTE_W;
    localparam int                PAD_BITS    = 8;
    localparam int                DUMP_BITS   = PAGE_BITS + PAD_BITS;

    ////////////////////////////////////////////////////////////////////////////
    // tap controller states
    typedef enum logic [3:0] {
        TAP_RESET  = 4'h0,
        TAP_IDLE   = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SH_DR  = 4'h4,
        TAP_EX1_DR = 4'h5,
        TAP_PA_DR  = 4'h6,
        TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'hA,
        TAP_SH_IR  = 4'hB,
        TAP_EX1_IR = 4'hC,
        TAP_PA_IR  = 4'hD,
        TAP_EX2_IR = 4'hE,
        TAP_UPD_IR = 4'hF
    } jfp_tap_t;

    // active data register
    typedef enum logic [2:0] {
        DR_BYPASS = 3'h0,
        DR_HOLD   = 3'h1,
        DR_UNLOCK = 3'h2,
        DR_CMD    = 3'h3,
        DR_FILL   = 3'h4,
        DR_DUMP   = 3'h5
    } jfp_dr_t;

endpackage

// ### rtl/jfp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ns
module jfp_sync
    import jfp_pkg::*;
#(
    parameter int W = 1
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } jfp_sync_st_t;

    jfp_sync_st_t s_q;
    jfp_sync_st_t s_d;

    always_comb
    begin
        s_d    = s_q;
        s_d.s1 = din;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign dout = s_q.s2;

endmodule

// ### rtl/jfp_pulse.sv
// toggle crossing: synchronise toggles and emit one-cycle pulses
`timescale 1ns/1ns
module jfp_pulse
    import jfp_pkg::*;
#(
    parameter int W = 1
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // toggles from the far domain
    input  wire logic [W-1:0] tgl,
    // one pulse per toggle
    output logic      [W-1:0] pulse
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } jfp_pulse_st_t;

    jfp_pulse_st_t p_q;
    jfp_pulse_st_t p_d;

    always_comb
    begin
        p_d    = p_q;
        p_d.s1 = tgl;
        p_d.s2 = p_q.s1;
        p_d.s3 = p_q.s2;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            p_q <= '0;
        else
            p_q <= p_d;
    end

    assign pulse = p_q.s2 ^ p_q.s3;

endmodule

// ### rtl/jfp_top.sv
// jtag data register paths for flash programming
//
// Notes on behaviour
// [RULE1] opcode 5 selects the 15-bit command register
// [RULE2] capture loads previous command result
// [RULE3] shift moves command one place per tck
// [RULE4] update presents new command, no execution
// [RULE5] idle entry gives exactly one execute pulse
// [RULE6] opcode 6 gives a 2048-bit fill chain
// [RULE7] 8-bit register, each byte to page buffer
// [RULE8] fill uses only shift, no update effect
// [RULE9] programmer uses fill only when first
// [RULE10] opcode 7 gives a 2056-bit dump chain
// [RULE11] dump reloads byte-wise in shift, not capture
// [RULE12] dump fetches bytes, shifts out, ignores tdi
// [RULE13] programmer uses dump only when first
// [RULE14] instruction selects the active data register
// [RULE15] all registers shift lsb first
// [RULE16] instruction register is four bits wide
// [RULE17] unlock signature enables programming at update
// [RULE18] dump chain leads with eight padding bits
// [RULE19] fill address steps, restarts on selection
`timescale 1ns/1ns
module jfp_top
    import jfp_pkg::*;
#(
    parameter int PAGE_BYTES_P = PAGE_BYTES,
    parameter int AW           = $clog2(PAGE_BYTES_P)
)
(
    // system clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // jtag link
    input  wire logic              tck,
    input  wire logic              tms,
    input  wire logic              tdi,
    output logic                   tdo,
    output logic                   tdo_oe_n,
    // command path to flash
    output logic      [CMD_W-1:0]  cmd_word,
    output logic                   cmd_exec,
    input  wire logic [CMD_W-1:0]  cmd_result,
    input  wire logic              cmd_result_vld,
    // page buffer write side
    output logic                   pbuf_wr,
    output logic      [AW-1:0]     pbuf_waddr,
    output logic      [BYTE_W-1:0] pbuf_wdata,
    // page buffer read side
    output logic                   pbuf_rd,
    output logic      [AW-1:0]     pbuf_raddr,
    input  wire logic [BYTE_W-1:0] pbuf_rdata,
    // status
    output logic                   prog_mode,
    output logic                   core_hold
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // tap state transitions
    function automatic jfp_tap_t jfp_tap_next(input jfp_tap_t s, input logic m);
        jfp_tap_t n;
        n = s;
        unique case (s)
            TAP_RESET:  n = m ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   n = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  n = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: n = m ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  n = m ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: n = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: n = m ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  n = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: n = m ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  n = m ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: n = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_IDLE;
        endcase
        return n;
    endfunction

    // data register chosen by instruction and unlock state
    function automatic jfp_dr_t jfp_dr_sel(input logic [IR_W-1:0] ir, input logic en);
        jfp_dr_t d;
        d = DR_BYPASS;
        if (ir == OP_HOLD)
            d = DR_HOLD;
        else if (ir == OP_UNLOCK)
            d = DR_UNLOCK;
        else if (en && ir == OP_CMD)
            d = DR_CMD;
        else if (en && ir == OP_FILL)
            d = DR_FILL;
        else if (en && ir == OP_DUMP)
            d = DR_DUMP;
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state of both domains

    typedef struct packed {
        jfp_tap_t                tap;
        logic [IR_W-1:0]         ir_sh;
        logic [IR_W-1:0]         ir;
        logic [CMD_W-1:0]        cmd_sh;
        logic [CMD_W-1:0]        cmd_app;
        logic [CMD_W-1:0]        res;
        logic                    res_seen;
        logic [UNLOCK_W-1:0]     unl_sh;
        logic                    prog_en;
        logic                    hold;
        logic                    byp;
        logic [BYTE_W-1:0]       sr8;
        logic [BYTE_W-1:0]       wbyte;
        logic [BIT_CNT_W-1:0]    bitc;
        logic                    upd_t;
        logic                    exec_t;
        logic                    wr_t;
        logic                    ack_t;
        logic                    fst_t;
        logic                    dst_t;
        logic                    tdo;
        logic                    oe_n;
    } jfp_tck_t;

    typedef struct packed {
        logic [CMD_W-1:0]  cmd;
        logic              exec;
        logic [CMD_W-1:0]  res;
        logic              res_t;
        logic [AW-1:0]     waddr;
        logic              wr;
        logic [BYTE_W-1:0] wdata;
        logic [AW-1:0]     raddr;
        logic              rd;
        logic [BYTE_W-1:0] rbyte;
    } jfp_clk_t;

    jfp_tck_t t_q;
    jfp_tck_t t_d;
    jfp_clk_t c_q;
    jfp_clk_t c_d;
    jfp_dr_t  sel_q;
    logic     res_tgl_s;
    logic     p_upd;
    logic     p_exec;
    logic     p_wr;
    logic     p_ack;
    logic     p_fst;
    logic     p_dst;

    ////////////////////////////////////////////////////////////////////////////
    // crossings

    jfp_pulse #(.W(6)) u_to_clk (
        .clk   (clk),
        .rst_n (rst_n),
        .tgl   ({t_q.upd_t, t_q.exec_t, t_q.wr_t, t_q.ack_t, t_q.fst_t, t_q.dst_t}),
        .pulse ({p_upd, p_exec, p_wr, p_ack, p_fst, p_dst})
    );

    jfp_sync #(.W(2)) u_lvl_clk (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({t_q.prog_en, t_q.hold}),
        .dout  ({prog_mode, core_hold})
    );

    jfp_sync #(.W(1)) u_res_tck (
        .clk   (tck),
        .rst_n (rst_n),
        .din   (c_q.res_t),
        .dout  (res_tgl_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link side, tck domain

    assign sel_q = jfp_dr_sel(t_q.ir, t_q.prog_en); // RULE14

    always_comb
    begin
        t_d     = t_q;
        t_d.tap = jfp_tap_next(t_q.tap, tms);
        // result word is stable once its toggle arrives
        if (res_tgl_s != t_q.res_seen)
        begin
            t_d.res_seen = res_tgl_s;
            t_d.res      = c_q.res;
        end
        unique case (t_q.tap)
            TAP_RESET:
            begin
                t_d.ir = OP_BYPASS;
            end
            TAP_CAP_IR:
            begin
                t_d.ir_sh = IR_CAPTURE;
            end
            TAP_SH_IR:
            begin
                t_d.ir_sh = {tdi, t_q.ir_sh[IR_W-1:1]}; // RULE16 RULE15
            end
            TAP_EX1_IR, TAP_EX2_IR:
            begin
                // instruction loads on the edge entering update
                if (tms)
                begin
                    t_d.ir = t_q.ir_sh; // RULE16
                    if (t_q.ir_sh == OP_FILL && t_q.prog_en)
                    begin
                        t_d.fst_t = ~t_q.fst_t; // RULE19
                        t_d.bitc  = '0;
                    end
                end
            end
            TAP_CAP_DR:
            begin
                unique case (sel_q)
                    DR_CMD:    t_d.cmd_sh = t_q.res; // RULE2
                    DR_BYPASS: t_d.byp = 1'b0;
                    DR_FILL:   t_d.bitc = '0;
                    DR_DUMP:
                    begin
                        // no load here, only the prefetch is started
                        t_d.bitc  = '0; // RULE11
                        t_d.dst_t = ~t_q.dst_t;
                    end
                    DR_HOLD, DR_UNLOCK: ;
                endcase
            end
            TAP_SH_DR:
            begin
                unique case (sel_q)
                    DR_BYPASS: t_d.byp = tdi;
                    DR_HOLD:   t_d.hold = tdi;
                    DR_UNLOCK: t_d.unl_sh = {tdi, t_q.unl_sh[UNLOCK_W-1:1]}; // RULE15
                    DR_CMD:    t_d.cmd_sh = {tdi, t_q.cmd_sh[CMD_W-1:1]}; // RULE3 RULE1
                    DR_FILL:
                    begin
                        t_d.sr8  = {tdi, t_q.sr8[BYTE_W-1:1]}; // RULE7 RULE15
                        t_d.bitc = t_q.bitc + 1'b1;
                        if (t_q.bitc == BYTE_LAST)
                        begin
                            t_d.wbyte = t_d.sr8; // RULE7 RULE6
                            t_d.wr_t  = ~t_q.wr_t;
                        end
                    end
                    DR_DUMP:
                    begin
                        t_d.sr8  = {1'b0, t_q.sr8[BYTE_W-1:1]}; // RULE12
                        t_d.bitc = t_q.bitc + 1'b1;
                        if (t_q.bitc == BYTE_LAST)
                        begin
                            // first eight bits out are padding
                            t_d.sr8   = c_q.rbyte; // RULE11 RULE18 RULE10
                            t_d.ack_t = ~t_q.ack_t;
                        end
                    end
                endcase
            end
            TAP_EX1_DR, TAP_EX2_DR:
            begin
                // update acts on the edge entering update, one tck before execute
                if (tms && sel_q == DR_CMD)
                begin
                    t_d.cmd_app = t_q.cmd_sh; // RULE4
                    t_d.upd_t   = ~t_q.upd_t;
                end
                if (tms && sel_q == DR_UNLOCK)
                    t_d.prog_en = (t_q.unl_sh == UNLOCK_SIG); // RULE17
                // fill and dump take no action here RULE8
            end
            TAP_IDLE, TAP_SEL_DR, TAP_PA_DR, TAP_UPD_DR,
            TAP_SEL_IR, TAP_PA_IR, TAP_UPD_IR: ;
        endcase
        // no pulse when leaving test-logic-reset with a stale instruction
        if (t_d.tap == TAP_IDLE && (t_q.tap == TAP_UPD_DR || t_q.tap == TAP_UPD_IR)
            && sel_q == DR_CMD)
            t_d.exec_t = ~t_q.exec_t; // RULE5
        // tdo holds the bit to be sampled at the next rising edge
        t_d.oe_n = !(t_d.tap == TAP_SH_DR || t_d.tap == TAP_SH_IR);
        if (t_d.tap == TAP_SH_IR)
            t_d.tdo = t_d.ir_sh[0];
        else
        begin
            unique case (jfp_dr_sel(t_d.ir, t_d.prog_en))
                DR_BYPASS:       t_d.tdo = t_d.byp;
                DR_HOLD:         t_d.tdo = t_d.hold;
                DR_UNLOCK:       t_d.tdo = t_d.unl_sh[0];
                DR_CMD:          t_d.tdo = t_d.cmd_sh[0]; // RULE3
                DR_FILL, DR_DUMP: t_d.tdo = t_d.sr8[0]; // RULE12
            endcase
        end
    end

    always_ff @(posedge tck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t_q         <= '0;
            t_q.tap     <= TAP_RESET;
            t_q.ir      <= OP_BYPASS;
            t_q.cmd_sh  <= CMD_RST;
            t_q.cmd_app <= CMD_RST;
            t_q.res     <= CMD_RST;
            t_q.oe_n    <= 1'b1;
        end
        else
            t_q <= t_d;
    end

    assign tdo      = t_q.tdo;
    assign tdo_oe_n = t_q.oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // flash side, clk domain

    always_comb
    begin
        c_d      = c_q;
        c_d.exec = 1'b0;
        c_d.wr   = 1'b0;
        c_d.rd   = 1'b0;
        if (cmd_result_vld)
        begin
            c_d.res   = cmd_result; // RULE2
            c_d.res_t = ~c_q.res_t;
        end
        if (p_upd)
            c_d.cmd = t_q.cmd_app; // RULE4
        if (p_exec)
            c_d.exec = 1'b1; // RULE5
        if (c_q.wr)
            c_d.waddr = c_q.waddr + 1'b1; // RULE19
        if (p_fst)
            c_d.waddr = '0; // RULE19
        if (p_wr)
        begin
            c_d.wr    = 1'b1; // RULE7
            c_d.wdata = t_q.wbyte;
        end
        if (c_q.rd)
        begin
            c_d.rbyte = pbuf_rdata; // RULE12
            c_d.raddr = c_q.raddr + 1'b1;
        end
        if (p_dst)
        begin
            c_d.raddr = '0;
            c_d.rd    = 1'b1; // RULE11
        end
        else if (p_ack)
            c_d.rd = 1'b1; // RULE12
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            c_q     <= '0;
            c_q.cmd <= CMD_RST;
            c_q.res <= CMD_RST;
        end
        else
            c_q <= c_d;
    end

    assign cmd_word   = c_q.cmd;
    assign cmd_exec   = c_q.exec;
    assign pbuf_wr    = c_q.wr;
    assign pbuf_waddr = c_q.waddr;
    assign pbuf_wdata = c_q.wdata;
    assign pbuf_rd    = c_q.rd;
    assign pbuf_raddr = c_q.raddr;

endmodule

// ### bench/jfp_top_checker.sv
// assertions on the flash programming port paths
`timescale 1ns/1ns
module jfp_top_checker
    import jfp_pkg::*;
#(
    parameter int PAGE_BYTES_P = PAGE_BYTES,
    parameter int AW           = 8
)
(
    // clocks and reset
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic             tck,
    // link
    input wire logic             tms,
    input wire logic             tdo_oe_n,
    // flash side
    input wire logic [CMD_W-1:0] cmd_word,
    input wire logic             cmd_exec,
    input wire logic             pbuf_wr,
    input wire logic [AW-1:0]    pbuf_waddr,
    input wire logic             pbuf_rd,
    input wire logic             prog_mode
);
    logic [AW-1:0] last_q;
    logic          seen_q;

    ////////////////////////////////////////////////////////////////////////////
    // last write address
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_q <= '0;
            seen_q <= 1'b0;
        end
        else if (pbuf_wr)
        begin
            last_q <= pbuf_waddr;
            seen_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // properties
    sequence s_wr_quiet;
        !pbuf_wr [*8];
    endsequence
    sequence s_rd_quiet;
        !pbuf_rd [*8];
    endsequence

    exec_single_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_exec |=> !cmd_exec [*8]) else $error("execute pulse repeated");
    exec_unlock_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_exec |-> prog_mode) else $error("execute while locked");
    word_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_exec |-> $stable(cmd_word)) else $error("word moved at execute");
    wr_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
        pbuf_wr |=> s_wr_quiet) else $error("page writes too close");
    wr_unlock_a: assert property (@(posedge clk) disable iff (!rst_n)
        pbuf_wr |-> prog_mode) else $error("page write while locked");
    wr_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        pbuf_wr && seen_q |-> pbuf_waddr == last_q + 1'b1 || pbuf_waddr == '0)
        else $error("write address skipped");
    rd_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
        pbuf_rd |=> s_rd_quiet) else $error("page reads too close");
    rd_unlock_a: assert property (@(posedge clk) disable iff (!rst_n)
        pbuf_rd |-> prog_mode) else $error("page read while locked");
    shift_exit_a: assert property (@(posedge tck) disable iff (!rst_n)
        tms |=> tdo_oe_n) else $error("output driven outside shift");
endmodule

bind jfp_top jfp_top_checker #(.PAGE_BYTES_P(PAGE_BYTES_P), .AW(AW)) chk (
    .clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdo_oe_n(tdo_oe_n),
    .cmd_word(cmd_word), .cmd_exec(cmd_exec), .pbuf_wr(pbuf_wr),
    .pbuf_waddr(pbuf_waddr), .pbuf_rd(pbuf_rd), .prog_mode(prog_mode));

// ### bench/jfp_prog.sv
// programmer model driving the test access port
`timescale 1ns/1ns
module jfp_prog
(
    // link outputs
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    // link inputs
    input  wire logic tdo,
    input  wire logic tdo_oe_n
);
    logic [2055:0] cap;

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one link clock, still between calls; sole device on chain
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #40 tck = 1'b1;
        #40 tck = 1'b0;
    endtask
    // lsb first in and out
    task automatic shift(input int n, input logic [2055:0] d);
        for (int i = 0; i < n; i++)
        begin
            cap[i] = tdo;
            step(i == n - 1, d[i]);
        end
    endtask
    task automatic ir(input logic [3:0] op);
        step(1'b1, ~tdi);
        step(1'b1, ~tdi);
        step(1'b0, ~tdi);
        step(1'b0, ~tdi);
        shift(4, {2052'h0, op});
        step(1'b1, ~tdi);
        step(1'b0, ~tdi);
    endtask
    // stops in update state
    task automatic dr(input int n, input logic [2055:0] d);
        step(1'b1, ~tdi);
        step(1'b0, ~tdi);
        step(1'b0, ~tdi);
        shift(n, d);
        step(1'b1, ~tdi);
    endtask
    // idle entry runs the applied command
    task automatic idle();
        step(1'b0, ~tdi);
    endtask
endmodule

// ### bench/tb_jfp_top.sv
// self-checking bench for the flash programming port paths
`timescale 1ns/1ns
`define CHK(a, b) \
    begin \
        checks++; \
        if ((a) !== (b)) \
        begin \
            failures++; \
            $display("Error %0t: got %h want %h", $time, (a), (b)); \
        end \
    end
module tb_jfp_top
    import jfp_pkg::*;
;
    logic              clk, rst_n, tck, tms, tdi, tdo, tdo_oe_n;
    logic              cmd_exec, cmd_result_vld, pbuf_wr, pbuf_rd, prog_mode, core_hold;
    logic [CMD_W-1:0]  cmd_word, cmd_result;
    logic [7:0]        pbuf_waddr, pbuf_wdata, pbuf_raddr, pbuf_rdata;
    logic [7:0]        wmem [256];
    logic [2055:0]     din;
    int                failures, checks, ecnt, wcnt;

    initial clk = 1'b0;
    always #25 clk = ~clk;

    jfp_top dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .cmd_word(cmd_word), .cmd_exec(cmd_exec),
        .cmd_result(cmd_result), .cmd_result_vld(cmd_result_vld), .pbuf_wr(pbuf_wr),
        .pbuf_waddr(pbuf_waddr), .pbuf_wdata(pbuf_wdata), .pbuf_rd(pbuf_rd),
        .pbuf_raddr(pbuf_raddr), .pbuf_rdata(pbuf_rdata), .prog_mode(prog_mode),
        .core_hold(core_hold));
    jfp_prog prg (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

    ////////////////////////////////////////////////////////////////////////////
    // flash side model and monitors
    function automatic logic [7:0] pat(input int i);
        return 8'(i) ^ 8'hA5;
    endfunction
    always @(negedge clk)
        pbuf_rdata <= pbuf_rd ? pat(int'(pbuf_raddr)) : ~pbuf_rdata;
    always @(posedge clk)
    begin
        if (cmd_exec)
            ecnt++;
        if (pbuf_wr)
        begin
            wmem[pbuf_waddr] = pbuf_wdata;
            wcnt++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic pause(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic t_lock();
        prg.ir(OP_CMD);
        `CHK(prg.cap[3:0], 4'h1)
        prg.dr(CMD_W, 2056'h1234);
        prg.idle();
        pause(8);
        `CHK(prg.cap[14:1], 14'h1234)
        `CHK({prog_mode, ecnt}, 33'h0)
        prg.ir(OP_UNLOCK);
        prg.dr(16, {2040'h0, ~UNLOCK_SIG});
        prg.idle();
        pause(6);
        `CHK(prog_mode, 1'b0)
        prg.dr(16, {2040'h0, UNLOCK_SIG});
        prg.idle();
        pause(6);
        `CHK(prog_mode, 1'b1)
    endtask
    task automatic t_cmd();
        logic [CMD_W-1:0] w;
        logic [CMD_W-1:0] r;
        int               e;
        prg.ir(OP_CMD);
        for (int k = 0; k < 2; k++)
        begin
            w = k ? 15'h7FFE : 15'h4001;
            r = k ? 15'h2AAA : 15'h5555;
            pause(1);
            cmd_result = r;
            cmd_result_vld = 1'b1;
            pause(1);
            cmd_result_vld = 1'b0;
            pause(4);
            // result crosses on link clock edges before capture
            prg.idle();
            e = ecnt;
            prg.dr(CMD_W, {2041'h0, w});
            pause(6);
            `CHK(prg.cap[14:0], r)
            `CHK(cmd_word, w)
            `CHK(ecnt, e)
            repeat (3) prg.idle();
            pause(6);
            `CHK(ecnt, e + 1)
        end
    endtask
    task automatic t_fill();
        int w0;
        for (int i = 0; i < 256; i++)
            din[8*i +: 8] = ~pat(i);
        prg.ir(OP_FILL);
        w0 = wcnt;
        prg.dr(PAGE_BITS, din);
        pause(8);
        `CHK(wcnt - w0, 256)
        for (int i = 0; i < 256; i++)
            `CHK(wmem[i], ~pat(i))
        prg.idle();
        pause(8);
        `CHK(wcnt - w0, 256)
        prg.ir(OP_FILL);
        prg.dr(16, 2056'h3CC3);
        prg.idle();
        pause(8);
        `CHK({wmem[1], wmem[0]}, 16'h3CC3)
    endtask
    task automatic t_dump();
        prg.ir(OP_DUMP);
        prg.dr(DUMP_BITS, din);
        prg.idle();
        for (int i = 0; i < 256; i++)
            `CHK(prg.cap[PAD_BITS + 8*i +: 8], pat(i))
    endtask
    task automatic t_hold();
        prg.ir(OP_HOLD);
        prg.dr(1, 2056'h1);
        prg.idle();
        pause(5);
        `CHK(core_hold, 1'b1)
        prg.dr(1, 2056'h0);
        prg.idle();
        pause(5);
        `CHK(core_hold, 1'b0)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // verdict, main sequence and watchdog
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        rst_n = 1'b0;
        cmd_result = '0;
        cmd_result_vld = 1'b0;
        pbuf_rdata = 8'h00;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        pause(3);
        prg.idle();
        t_lock();
        t_cmd();
        t_fill();
        t_dump();
        t_hold();
        give_verdict();
    end
    initial
    begin
        #2000000;
        failures++;
        give_verdict();
    end
endmodule
